//--- src/tpg_pkg.sv
// package: register map, layouts and constants
package tpg_pkg;

   // ================
   // register byte offsets on the avalon slave
   localparam logic [4:0] OFF_CTRL = 5'h00; // mode, polarity, lengths
   localparam logic [4:0] OFF_ZCNT = 5'h04; // substituted zero count
   localparam logic [4:0] OFF_PSEL = 5'h08; // stored pattern select
   localparam logic [4:0] OFF_LOAD = 5'h0C; // commit: slot and length
   localparam logic [4:0] OFF_PDATA = 5'h10; // pattern word push
   localparam logic [4:0] OFF_MIX = 5'h14; // mixed block geometry
   localparam logic [4:0] OFF_AREA = 5'h18; // scramble area enables
   localparam logic [4:0] OFF_STAT = 5'h1C; // status, read only

   // ================
   // field positions
   localparam int LOAD_LEN_LSB = 8; // word count field of LOAD
   localparam int PSEL_MAX_LSB = 8; // resident slot limit in PSEL
   localparam int AREA_SET_ALL = 31; // enable_all_areas command bit
   localparam int AREA_CLR_ALL = 30; // disable_all_areas command bit
   localparam int STAT_LOAD_BIT = 0; // loading indicator
   localparam int STAT_RES_LSB = 4; // resident slot bits
   localparam int STAT_ACT_LSB = 12; // slot on the wire

   // ================
   // modes and segment states, gray along the usual path
   typedef enum logic [1:0] {
      MODE_ZERO_INSERT = 2'h0,
      MODE_DATA = 2'h1,
      MODE_MIXED = 2'h3
   } tpg_mode_t;

   typedef enum logic {
      SEG_DATA = 1'b0,
      SEG_PRBS = 1'b1
   } tpg_seg_t;

   // ================
   // register layouts
   typedef struct packed {
      logic [2:0] stage; // stage code, see stage_n
      logic consec; // 1 consecutive, 0 restart generation
      logic scr_on; // scramble control
      logic last_bit; // last bit value of the 2^n length
      logic len_pow2; // 1: 2^n length, 0: 2^n-1 length
      logic inverted_polarity; // high level means logic zero
      tpg_mode_t mode;
   } tpg_ctrl_t;

   typedef struct packed {
      logic [7:0] dbits; // data bits per row
      logic [3:0] rows; // rows per block
      logic [8:0] blocks; // blocks per pattern
   } tpg_mix_t;

   // ================
   // reset values and limits
   localparam tpg_ctrl_t CTRL_RST = 10'h000;
   localparam tpg_mix_t MIX_RST = 21'h0_2202;
   localparam logic [30:0] ZCNT_RST = 31'h0000_0001;
   localparam logic [15:0] AREA_RST = 16'h0000;
   localparam logic [3:0] MIN_ROWS = 4'h2;
   localparam logic [30:0] LFSR_SEED = 31'h7FFF_FFFF;
   localparam logic [6:0] SCR_SEED = 7'h7F;
   localparam logic [2:0] STAGE_MAX_ZI = 3'h6; // zero insert tops at 23

   // ================
   // stage code to register length and feedback tap
   function automatic logic [4:0] stage_n(input logic [2:0] c);
      case (c)
         3'h0: return 5'h07;
         3'h1: return 5'h09;
         3'h2: return 5'h0A;
         3'h3: return 5'h0B;
         3'h4: return 5'h0F;
         3'h5: return 5'h14;
         3'h6: return 5'h17;
         default: return 5'h1F;
      endcase
   endfunction : stage_n

   function automatic logic [4:0] stage_tap(input logic [2:0] c);
      case (c)
         3'h0: return 5'h06;
         3'h1: return 5'h05;
         3'h2: return 5'h07;
         3'h3: return 5'h09;
         3'h4: return 5'h0E;
         3'h5: return 5'h03;
         3'h6: return 5'h12;
         default: return 5'h1C;
      endcase
   endfunction : stage_tap

endpackage : tpg_pkg

//--- src/tpg_fifo.sv
// pattern word fifo between the register bus and the pattern memory
`timescale 1ns/1ps
module tpg_fifo import tpg_pkg::*; #(
   parameter int W = 32,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   // depth must be a power of two so pointers wrap on their own
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem_q [DEPTH]; // storage
   logic [AW-1:0] wp_q; // write pointer
   logic [AW-1:0] rp_q; // read pointer
   logic [AW:0] cnt_q; // words held
   logic push;
   logic pop;

   assign in_ready = cnt_q != (AW+1)'(DEPTH);
   assign out_valid = cnt_q != '0;
   assign out_data = mem_q[rp_q];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // ================
   // storage, no reset needed on data
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wp_q <= wp_q + 1'b1;
         if (pop) rp_q <= rp_q + 1'b1;
         if (push && !pop) cnt_q <= cnt_q + 1'b1;
         else if (pop && !push) cnt_q <= cnt_q - 1'b1;
      end
   end
endmodule : tpg_fifo

//--- src/tpg_top.sv
// serial test pattern generator with avalon register slave
//
// Overview of operation
// - zero insert length 2^n or 2^n-1, listed n
// - polarity control inverts the line level
// - zero count 1 to 2^n-2 or 2^n-1
// - last bit one, or extra zero appended
// - last bit ignored for 2^n-1 length
// - mode select starts load, loading shown; here only a zero insert select reloads, shown for two cycles
// - several slots held, seamless pattern switch
// - slot limit; resident slot not reloaded on select
// - committed pattern loaded with loading shown
// - rows are data then prbs; blocks at least two rows
// - at most 511 blocks per mixed pattern
// - mixed prbs length 2^n-1, n up to 31
// - prbs7 scrambling on enabled areas only
// - per area enables, set all, clear all
// - first row data never scrambled
// - restart reseeds per block; consecutive continues
// - pattern repeat always continues the prbs
//
// Chosen here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
module tpg_top import tpg_pkg::*; #(
   parameter int NPAT = 4, // stored pattern slots
   parameter int MWORDS = 64, // 32 bit words per slot
   parameter int FDEPTH = 8 // load fifo depth
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // avalon-mm slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // pattern line and indicator
   output logic serial_out,
   output logic loading
);
   localparam int SW = (NPAT > 1) ? $clog2(NPAT) : 1;
   localparam int AW = $clog2(MWORDS);
   localparam int PW = AW + 5; // bit pointer within a slot

   // ================
   // registers
   tpg_ctrl_t ctrl_q; // mode and options
   logic [30:0] zcnt_q; // requested zero count
   logic [SW-1:0] sel_q; // slot software wants
   logic [SW:0] maxpat_q; // slots that may be loaded
   tpg_mix_t mix_q; // mixed geometry
   logic [15:0] area_q; // scramble area enables
   logic [31:0] rdata_q;
   logic wait_q;
   logic out_q;
   logic loading_q;

   // load engine
   logic load_act_q; // a committed load runs
   logic [SW-1:0] load_slot_q;
   logic [AW:0] load_len_q; // words expected
   logic [AW:0] push_cnt_q; // words taken from the bus
   logic [AW:0] wr_cnt_q; // words written to memory
   logic [NPAT-1:0] res_q; // slot holds a full pattern
   logic [AW:0] slen_q [NPAT]; // words per resident slot
   logic [31:0] mem_q [2**(SW+AW)]; // pattern memory
   logic zi_load_q; // zero insert reload in progress

   // generator
   logic [30:0] lfsr_q;
   logic [6:0] scr_q;
   logic [31:0] zpos_q; // position in zero insert period
   logic [PW-1:0] ptr_q; // data bit pointer
   logic [31:0] word_q; // current data word
   logic [SW-1:0] act_q; // slot on the wire
   tpg_seg_t seg_q;
   logic [31:0] cnt_q; // bit count within segment
   logic [3:0] row_q;
   logic [8:0] blk_q;

   // ================
   // bus decode
   logic req;
   logic is_pdata;
   logic push_ok;
   logic ok;
   logic wr_fire;
   logic [31:0] rmux;
   logic f_in_ready;
   logic f_out_valid;
   logic f_out_ready;
   logic [31:0] f_out_data;
   logic f_push;
   logic fetch;

   assign req = (avs_read | avs_write) & wait_q;
   assign is_pdata = avs_address == OFF_PDATA;
   assign push_ok = load_act_q && push_cnt_q != load_len_q;
   // a pdata write stalls only while it would really enter the fifo
   assign ok = !(avs_write && is_pdata && push_ok && !f_in_ready);
   assign wr_fire = avs_write & ~wait_q;
   assign f_push = wr_fire & is_pdata & push_ok;
   // drain yields only to live fetches; an idle slot would starve it
   assign f_out_ready = load_act_q & ~(fetch & res_q[act_q]);

   // read mux, unmapped offsets read zero
   always_comb begin
      rmux = 32'h0000_0000;
      unique case (avs_address)
         OFF_CTRL: rmux = 32'(ctrl_q);
         OFF_ZCNT: rmux = {1'b0, zcnt_q};
         OFF_PSEL: rmux = 32'(sel_q) | (32'(maxpat_q) << PSEL_MAX_LSB);
         OFF_MIX: rmux = 32'(mix_q);
         OFF_AREA: rmux = {16'h0000, area_q};
         OFF_STAT: begin
            rmux = (32'(loading_q) << STAT_LOAD_BIT)
               | (32'(res_q) << STAT_RES_LSB)
               | (32'(act_q) << STAT_ACT_LSB);
         end
         default: rmux = 32'h0000_0000;
      endcase
   end

   // handshake: waitrequest idles high, drops for one accepting edge
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         wait_q <= ~(req & ok);
         if (req && ok && avs_read) rdata_q <= rmux;
      end
   end

   // ================
   // configuration registers
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ctrl_q <= CTRL_RST;
         zcnt_q <= ZCNT_RST;
         sel_q <= '0;
         maxpat_q <= (SW+1)'(NPAT);
         mix_q <= MIX_RST;
         area_q <= AREA_RST;
      end else if (wr_fire) begin
         unique case (avs_address)
            OFF_CTRL: ctrl_q <= tpg_ctrl_t'(avs_writedata[9:0]);
            OFF_ZCNT: zcnt_q <= avs_writedata[30:0];
            OFF_PSEL: begin
               sel_q <= avs_writedata[SW-1:0];
               // a slot limit beyond what the memory holds is ignored, the old limit stays
               if (avs_writedata[PSEL_MAX_LSB +: SW+1] <= (SW+1)'(NPAT))
                  maxpat_q <= avs_writedata[PSEL_MAX_LSB +: SW+1];
            end
            OFF_MIX: mix_q <= tpg_mix_t'(avs_writedata[20:0]);
            OFF_AREA: begin
               if (avs_writedata[AREA_SET_ALL])
                  area_q <= 16'hFFFF;
               else if (avs_writedata[AREA_CLR_ALL])
                  area_q <= 16'h0000;
               else if (avs_writedata[15:0] != 16'h0000)
                  area_q <= avs_writedata[15:0];
            end
            default: ;
         endcase
      end
   end

   // ================
   // pattern load path through the fifo
   tpg_fifo #(
      .W(32),
      .DEPTH(FDEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .srst(srst),
      .in_valid(f_push),
      .in_ready(f_in_ready),
      .in_data(avs_writedata),
      .out_valid(f_out_valid),
      .out_ready(f_out_ready),
      .out_data(f_out_data)
   );

   logic pop;
   logic commit;
   logic [SW-1:0] c_slot;
   logic [AW:0] c_len;
   assign pop = f_out_valid & f_out_ready;
   assign commit = wr_fire && avs_address == OFF_LOAD;
   assign c_slot = avs_writedata[SW-1:0];
   assign c_len = avs_writedata[LOAD_LEN_LSB +: AW+1];

   // memory write port
   always_ff @(posedge clk_sys) begin
      if (pop) mem_q[{load_slot_q, wr_cnt_q[AW-1:0]}] <= f_out_data;
   end

   // load control; a commit beyond the slot limit is ignored
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         load_act_q <= 1'b0;
         load_slot_q <= '0;
         load_len_q <= '0;
         push_cnt_q <= '0;
         wr_cnt_q <= '0;
         res_q <= '0;
      end else if (commit && !load_act_q && (SW+1)'(c_slot) < maxpat_q
            && c_len != '0 && c_len <= (AW+1)'(MWORDS)) begin
         load_act_q <= 1'b1;
         load_slot_q <= c_slot;
         load_len_q <= c_len;
         push_cnt_q <= '0;
         wr_cnt_q <= '0;
         res_q[c_slot] <= 1'b0;
      end else begin
         if (f_push) push_cnt_q <= push_cnt_q + 1'b1;
         if (pop) begin
            wr_cnt_q <= wr_cnt_q + 1'b1;
            if (wr_cnt_q + 1'b1 == load_len_q) begin
               load_act_q <= 1'b0;
               res_q[load_slot_q] <= 1'b1;
            end
         end
      end
   end

   // slot lengths kept once the slot is complete
   always_ff @(posedge clk_sys) begin
      if (pop && wr_cnt_q + 1'b1 == load_len_q)
         slen_q[load_slot_q] <= load_len_q;
   end

   // ================
   // generator decode
   logic restart;
   logic [2:0] code;
   logic [4:0] n_w;
   logic [4:0] t_w;
   logic [31:0] ones;
   logic [31:0] period;
   logic [31:0] zc;
   logic prbs_bit;
   logic [30:0] lfsr_nx;
   logic [3:0] rows_e;
   logic [8:0] blks_e;
   logic [31:0] dbits_e;
   logic [PW-1:0] lenbits;
   logic [PW-1:0] nptr;
   logic [SW-1:0] nslot;
   logic bit_w;
   logic padv;
   logic dadv;
   logic zi_end;
   logic d_end;
   logic p_end;
   logic row_end;
   logic blk_last;
   logic reseed;
   logic scr_en;

   assign restart = wr_fire && avs_address == OFF_CTRL;
   assign code = (ctrl_q.mode == MODE_ZERO_INSERT
      && ctrl_q.stage > STAGE_MAX_ZI) ? STAGE_MAX_ZI : ctrl_q.stage;
   assign n_w = stage_n(code);
   assign t_w = stage_tap(code);
   assign ones = (32'h0000_0001 << n_w) - 32'h0000_0001;
   // the last bit only exists with the 2^n length
   assign period = ctrl_q.len_pow2 ? ones + 32'h0000_0001 : ones;
   // zero count held to 1 .. period-1
   assign zc = ({1'b0, zcnt_q} == 32'h0) ? 32'h0000_0001
      : ({1'b0, zcnt_q} > period - 32'h1) ? period - 32'h1 : {1'b0, zcnt_q};
   assign prbs_bit = lfsr_q[n_w - 5'h01];
   assign lfsr_nx = {lfsr_q[29:0],
      lfsr_q[n_w - 5'h01] ^ lfsr_q[t_w - 5'h01]} & ones[30:0];
   assign rows_e = (mix_q.rows < MIN_ROWS) ? MIN_ROWS : mix_q.rows;
   assign blks_e = (mix_q.blocks == 9'h000) ? 9'h001 : mix_q.blocks;
   assign dbits_e = (mix_q.dbits == 8'h00) ? 32'h1 : 32'(mix_q.dbits);
   assign lenbits = PW'(slen_q[act_q]) << 5;
   assign zi_end = zpos_q == period - 32'h1;
   assign d_end = seg_q == SEG_DATA && cnt_q == dbits_e - 32'h1;
   assign p_end = seg_q == SEG_PRBS && cnt_q == ones - 32'h1;
   assign row_end = p_end && row_q == rows_e - 4'h1;
   assign blk_last = blk_q == blks_e - 9'h001;
   // wrap of the whole pattern never reseeds
   assign reseed = row_end && !blk_last && !ctrl_q.consec;
   // per area enable; the first row data area is never scrambled
   assign scr_en = ctrl_q.scr_on && area_q[{row_q[2:0], seg_q}]
      && !(row_q == 4'h0 && seg_q == SEG_DATA);

   // bit selection per mode
   always_comb begin
      bit_w = 1'b0;
      padv = 1'b0;
      dadv = 1'b0;
      unique case (ctrl_q.mode)
         MODE_ZERO_INSERT: begin
            if (zpos_q < zc) begin
               padv = 1'b1; // substituted zeros
            end else if (ctrl_q.len_pow2 && zi_end) begin
               bit_w = ctrl_q.last_bit;
            end else begin
               bit_w = prbs_bit;
               padv = 1'b1;
            end
         end
         MODE_DATA: begin
            bit_w = word_q[ptr_q[4:0]];
            dadv = res_q[act_q];
         end
         MODE_MIXED: begin
            if (seg_q == SEG_DATA) begin
               bit_w = word_q[ptr_q[4:0]];
               dadv = res_q[act_q];
            end else begin
               bit_w = prbs_bit;
               padv = 1'b1;
            end
            if (scr_en) bit_w = bit_w ^ scr_q[6];
         end
         default: ;
      endcase
   end

   // next data pointer; slot switch at the pattern end, or at once from an empty slot
   always_comb begin
      nptr = ptr_q + 1'b1;
      nslot = act_q;
      if (!res_q[act_q]) begin
         nptr = '0;
         nslot = sel_q; // an empty slot yields at once
      end else if (nptr == lenbits) begin
         nptr = '0;
         if (res_q[sel_q]) nslot = sel_q;
      end
   end
   assign fetch = (dadv || !res_q[act_q]) && nptr[4:0] == 5'h00;

   // ================
   // prbs and scrambler state
   always_ff @(posedge clk_sys) begin
      if (srst || restart || reseed) begin
         lfsr_q <= LFSR_SEED;
      end else if (padv) begin
         lfsr_q <= lfsr_nx;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst || restart) begin
         scr_q <= SCR_SEED;
      end else if (ctrl_q.mode == MODE_MIXED) begin
         scr_q <= {scr_q[5:0], scr_q[6] ^ scr_q[5]};
      end
   end

   // zero insert period position
   always_ff @(posedge clk_sys) begin
      if (srst || restart || zi_end) begin
         zpos_q <= 32'h0000_0000;
      end else begin
         zpos_q <= zpos_q + 32'h0000_0001;
      end
   end

   // data pointer, current word and slot on the wire
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ptr_q <= '0;
         act_q <= '0;
         word_q <= 32'h0000_0000;
      end else if (dadv || !res_q[act_q]) begin
         ptr_q <= nptr;
         act_q <= nslot;
         if (fetch) word_q <= mem_q[{nslot, nptr[PW-1:5]}];
      end
   end

   // mixed segment, row and block walk
   always_ff @(posedge clk_sys) begin
      if (srst || restart) begin
         seg_q <= SEG_DATA;
         cnt_q <= 32'h0000_0000;
         row_q <= 4'h0;
         blk_q <= 9'h000;
      end else if (ctrl_q.mode == MODE_MIXED) begin
         unique case (seg_q)
            SEG_DATA: begin
               cnt_q <= d_end ? 32'h0 : cnt_q + 32'h1;
               if (d_end) seg_q <= SEG_PRBS;
            end
            SEG_PRBS: begin
               cnt_q <= p_end ? 32'h0 : cnt_q + 32'h1;
               if (p_end) begin
                  seg_q <= SEG_DATA;
                  row_q <= row_end ? 4'h0 : row_q + 4'h1;
               end
               if (row_end) blk_q <= blk_last ? 9'h000 : blk_q + 9'h001;
            end
         endcase
      end
   end

   // ================
   // zero insert reload after a mode select, shown for two cycles
   logic zi_start;
   assign zi_start = restart && avs_writedata[1:0] == MODE_ZERO_INSERT;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         zi_load_q <= 1'b0;
      end else begin
         zi_load_q <= zi_start;
      end
   end

   // loading covers commits, zero insert reloads and, in data mode, a selected slot not yet resident
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         loading_q <= 1'b0;
      end else begin
         loading_q <= load_act_q | zi_load_q | zi_start
            | (ctrl_q.mode == MODE_DATA && !res_q[sel_q]);
      end
   end

   // line output with polarity
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         out_q <= 1'b0;
      end else begin
         out_q <= bit_w ^ ctrl_q.inverted_polarity;
      end
   end

   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
   assign serial_out = out_q;
   assign loading = loading_q;
endmodule : tpg_top

//--- dv/tpg_top_chk.sv
// checker: bus handshake and loading indicator
`timescale 1ns/1ps
module tpg_chk import tpg_pkg::*; #(
   parameter int NPAT = 4,
   parameter int MWORDS = 64
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // avalon-mm slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // line and indicator
   input wire logic serial_out,
   input wire logic loading
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   // ================
   // accepted writes that may start a load
   logic acc_w; // write taken this cycle
   logic cfg_w; // write to a load-capable register
   logic ld_ok; // load command with legal fields
   assign acc_w = avs_write && !avs_waitrequest;
   assign cfg_w = acc_w && (avs_address == OFF_LOAD ||
      avs_address == OFF_CTRL || avs_address == OFF_PSEL);
   assign ld_ok = acc_w && avs_address == OFF_LOAD &&
      avs_writedata[7:0] < NPAT && avs_writedata[15:8] != 8'h00 &&
      avs_writedata[15:8] <= MWORDS;
   // ================
   // handshake
   chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("wait low too long");
   chk_wait_cause: assert property (
      !(avs_read || avs_write) |=> avs_waitrequest)
      else $error("stray accept");
   chk_ack_fast: assert property (
      (avs_read || avs_write) && avs_address != OFF_PDATA
      |-> ##[0:1] !avs_waitrequest)
      else $error("late answer");
   // read data moves only on a read
   chk_rd_stable: assert property (
      !(avs_read && !avs_waitrequest) |-> $stable(avs_readdata))
      else $error("read data moved");
   chk_rd_unmap: assert property (
      avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0
      |-> avs_readdata == 32'h0000_0000)
      else $error("unmapped data");
   // ================
   // loading indicator
   chk_load_start: assert property (ld_ok && !loading |-> ##[1:2] loading)
      else $error("load not shown");
   chk_load_cause: assert property ($rose(loading) |->
      $past(cfg_w, 1) || $past(cfg_w, 2) || $past(cfg_w, 3))
      else $error("stray loading");
   chk_load_min: assert property ($rose(loading) |=> loading)
      else $error("loading too short");
   chk_stat_load: assert property (
      avs_read && !avs_waitrequest && avs_address == OFF_STAT
      |-> avs_readdata[STAT_LOAD_BIT] == loading ||
      avs_readdata[STAT_LOAD_BIT] == $past(loading))
      else $error("status loading bit");
endmodule : tpg_chk

bind tpg_top tpg_chk #(.NPAT(NPAT), .MWORDS(MWORDS))
   tpg_chk_inst (.clk_sys(clk_sys), .srst(srst),
   .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .serial_out(serial_out), .loading(loading));

//--- dv/tpg_rx.sv
// receiver model: collects line bits
`timescale 1ns/1ps
module tpg_rx import tpg_pkg::*; (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // line and capture window
   input wire logic serial_out,
   input wire logic cap_en
);
   // ================
   // raw line levels in arrival order
   logic bits[$];
   // one bit per clock in the window
   always @(posedge clk_sys) begin
      if (srst) begin
         bits.delete();
      end else if (cap_en) begin
         bits.push_back(serial_out);
      end
   end
endmodule : tpg_rx

//--- dv/tb_tpg_top.sv
// bench: bus tasks, stream models and run sequence
`timescale 1ns/1ps
module tb_tpg_top import tpg_pkg::*; ;
   // ================
   // design signals
   logic clk_sys = 0, srst = 1, avs_read = 0, avs_write = 0, cap_en = 0;
   logic [4:0] avs_address = 5'h00;
   logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q;
   logic avs_waitrequest, serial_out, loading;
   int err_total = 0, checked = 0, cyc = 0, hi = 0;
   logic w[$]; // expected data period
   // reset values, area steps, zero insertion cases
   logic [4:0] ra[5] = '{OFF_CTRL, OFF_ZCNT, OFF_PSEL, OFF_AREA, OFF_STAT};
   logic [31:0] rx[5] = '{0, 1, 32'h0000_0400, 0, 0};
   logic [31:0] aw[4] = '{32'h8000_0000, 5, 0, 32'h4000_0000};
   logic [31:0] ax[4] = '{32'h0000_FFFF, 5, 5, 0};
   logic [31:0] zc[4] = '{0, 32'h0000_0014, 32'h0000_0018, 32'h0000_000C};
   int zz[4] = '{1, 126, 127, 0};
   always #20 clk_sys = ~clk_sys;
   tpg_top #(.NPAT(4), .MWORDS(64), .FDEPTH(8)) tpg_top_inst (
      .clk_sys(clk_sys), .srst(srst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .serial_out(serial_out),
      .loading(loading));
   tpg_rx tpg_rx_inst (.clk_sys(clk_sys), .srst(srst),
      .serial_out(serial_out), .cap_en(cap_en));
   // ================
   // verdict, hang guard, compare
   task automatic final_report();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report
   // a hang is a mismatch; count loading in captures
   always @(posedge clk_sys) begin
      cyc++;
      if (cap_en && loading === 1'b1) hi++;
      if (cyc == 30000) begin
         err_total++;
         final_report();
      end
   end
   task automatic check(input logic [31:0] s, e, input string m);
      checked++;
      if (s !== e) begin
         err_total++;
         $display("ERROR t=%0t %s seen %h exp %h", $time, m, s, e);
      end
   endtask : check
   // one access, held until waitrequest is low
   task automatic bus(input logic wr, input logic [4:0] a,
      input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
      q = avs_readdata;
      avs_write <= 0;
      avs_read <= 0;
      @(posedge clk_sys);
   endtask : bus
   // wait out a load, then capture n bits
   task automatic cap(input int n);
      repeat (3) @(posedge clk_sys);
      while (loading !== 1'b0) @(posedge clk_sys);
      tpg_rx_inst.bits.delete();
      cap_en <= 1;
      repeat (n) @(posedge clk_sys);
      cap_en <= 0;
      @(posedge clk_sys);
   endtask : cap
   // ================
   // capture must rotate period e
   function automatic bit rot_ok(input logic e[$]);
      for (int r = 0; r < e.size(); r++) begin
         int i;
         for (i = 0; i < tpg_rx_inst.bits.size(); i++)
            if (tpg_rx_inst.bits[i] !== e[(i + r) % e.size()]) break;
         if (i == tpg_rx_inst.bits.size()) return 1;
      end
      return 0;
   endfunction : rot_ok
   // prbs7, either sense, any phase, z leading zeros
   function automatic bit zi_ok(input int z, input logic [31:0] c);
      logic m[$], e[$];
      logic [6:0] st = 7'h7F;
      int j;
      for (int i = 0; i < 127; i++) begin
         m.push_back(st[6]);
         st = {st[5:0], st[6] ^ st[5]};
      end
      for (int s = 0; s < 254; s++) begin
         e.delete();
         for (int i = 0; i < 127; i++) begin
            j = (s % 127 + i) % 127;
            e.push_back((i < z ? 1'b0 : m[s > 126 ? 126 - j : j]) ^ c[2]);
         end
         if (c[3]) e.push_back(c[4] ^ c[2]);
         if (rot_ok(e)) return 1;
      end
      return 0;
   endfunction : zi_ok
   // ================
   // run sequence
   initial begin
      int z;
      void'($urandom(8701));
      repeat (5) @(posedge clk_sys);
      srst <= 0;
      @(posedge clk_sys);
      for (int k = 0; k < 5; k++) begin
         bus(0, ra[k], 0);
         check(q, rx[k], "reset value");
      end
      bus(1, 5'h02, 32'hFFFF_FFFF);
      bus(0, 5'h02, 0);
      check(q, 0, "unmapped read");
      bus(0, OFF_CTRL, 0);
      check(q, 0, "stray write");
      for (int k = 0; k < 4; k++) begin
         bus(1, OFF_AREA, aw[k]);
         bus(0, OFF_AREA, 0);
         check(q, ax[k], "area");
      end
      // zero insert: edge counts, lengths, polarities
      for (int k = 0; k < 4; k++) begin
         z = (k == 3) ? 1 + $urandom % 126 : zz[k];
         bus(1, OFF_ZCNT, 32'(z));
         bus(1, OFF_CTRL, zc[k]);
         cap(260);
         check(zi_ok(z, zc[k]), 1, "zero insert");
      end
      // ten random words into slot 0, then play it
      bus(1, OFF_LOAD, 32'h0000_0A00);
      @(posedge clk_sys);
      check(loading, 1, "loading");
      repeat (10) begin
         q = $urandom;
         for (int i = 0; i < 32; i++) w.push_back(q[i]);
         bus(1, OFF_PDATA, q);
      end
      cap(1);
      bus(0, OFF_STAT, 0);
      check(q[STAT_RES_LSB], 1, "resident");
      bus(1, OFF_PSEL, 32'h0000_0400);
      bus(1, OFF_CTRL, 32'(MODE_DATA));
      cap(640);
      check(rot_ok(w), 1, "data");
      // one word to slot 1, then select it
      w.delete();
      bus(1, OFF_LOAD, 32'h0000_0101);
      q = $urandom;
      for (int i = 0; i < 32; i++) w.push_back(q[i]);
      bus(1, OFF_PDATA, q);
      cap(1);
      hi = 0;
      bus(1, OFF_PSEL, 32'h0000_0401);
      cap(400);
      check(hi, 0, "resident reload");
      cap(64);
      check(rot_ok(w), 1, "switch");
      final_report();
   end
endmodule : tb_tpg_top
